// ===== logic/voice_rtp_compact_payload_framer.v
// compact payload framer: packs encoder bits into compact or
// header-full payload bits and parses received compact payloads.
// assumes same-clock encoder, decoder and packetiser, and a
// classic wishbone master; header-full parsing lives elsewhere.
// Notes on behaviour
// - bytes and bits travel most significant first
// - timestamp adds 320 per 20 ms frame-block at 16 kHz
// - marker is one only for packets opening a talkspurt
// - native compact payload is one frame with no payload header
// - native rate follows from payload size, 48 to 2560 bits
// - interop rate follows from payload size, 136 to 480 bits
// - native bits go out in encoder production order
// - interop payload: 3-bit request, d(1) onward, then d(0)
// - request codes 000..110 name interop rates, 111 means none
// - a received none code is ignored
// - unsupported compact requests are lowered to next allowed mode
// - requests outside the negotiated mode set are discarded
// - valid request switches sender to interop, never above it
// - zero bits pad request plus speech to whole octets
// - interop silence descriptors go header-full with request byte
// - damaged legacy frames are dropped, not converted
// - native-rate requests never use the compact field
// - interop bits come in sensitivity order, one 20 ms frame
// - layouts may alternate unless header-full only is set
// - 56 bits: leading zero native, leading one header-full
// - a received request stays until a newer one arrives
// - header-full zero padding is discarded by its parser
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "voice_framer_regs.vh"
module voice_rtp_compact_payload_framer #(
  parameter MAX_BITS = `SZ_N128,
  parameter CNT_W    = 12
) (
  // clock, reset, enable
  input  wire             ref_clk,
  input  wire             reset_n,
  input  wire             ce,
  // wishbone slave
  input  wire             cyc_i,
  input  wire             stb_i,
  input  wire             we_i,
  input  wire [7:0]       adr_i,
  input  wire [31:0]      dat_i,
  input  wire [3:0]       sel_i,
  output reg  [31:0]      dat_o,
  output reg              ack_o,
  // encoder bits in production order
  input  wire             enc_bit,
  input  wire             enc_valid,
  input  wire             enc_last,
  input  wire             enc_talk_start,
  input  wire             enc_sid,
  input  wire             enc_damaged,
  output wire             enc_ready,
  output wire             tx_interop,
  output wire [3:0]       tx_rate,
  // outgoing payload bits
  output reg              tx_bit,
  output reg              tx_valid,
  output reg              tx_last,
  input  wire             tx_ready,
  output reg              tx_marker,
  output reg  [31:0]      tx_timestamp,
  output reg              tx_header_full,
  // incoming payload bits
  input  wire             rx_bit,
  input  wire             rx_valid,
  input  wire             rx_last,
  output wire             rx_ready,
  // decoder bits and frame attributes
  output reg              dec_bit,
  output reg              dec_valid,
  output reg              dec_last,
  input  wire             dec_ready,
  output reg              dec_interop,
  output reg  [3:0]       dec_rate,
  output reg              hf_divert,
  output reg  [CNT_W-1:0] hf_size
);

  localparam [31:0]      TS_STEP = `TS_CLOCK_KHZ * `FRAME_MS;
  localparam [CNT_W-1:0] MAXC    = MAX_BITS;
  localparam [CNT_W-1:0] ONE     = 1;
  localparam [CNT_W-1:0] CMR_N   = `CMR_BITS;
  localparam [CNT_W-1:0] CMR_M1  = `CMR_BITS - 3'h1;
  localparam [1:0] RX_FILL = 2'h0;
  localparam [1:0] RX_CLASS = 2'h1;
  localparam [1:0] RX_OUT  = 2'h2;
  localparam [2:0] T_IDLE  = 3'h0;
  localparam [2:0] T_HDR   = 3'h1;
  localparam [2:0] T_HOLD  = 3'h2;
  localparam [2:0] T_BODY  = 3'h3;
  localparam [2:0] T_D0    = 3'h4;
  localparam [2:0] T_PAD   = 3'h5;
  localparam [2:0] T_DROP  = 3'h6;

  // ------------
  // decoding functions
  // ------------
  // native rate code from payload size, none if not native
  function [3:0] nat_code;
    input [CNT_W-1:0] s;
    begin
      case (s)
        `SZ_NSID: nat_code = 4'h0;
        `SZ_N28:  nat_code = 4'h1;
        `SZ_N72:  nat_code = 4'h2;
        `SZ_N80:  nat_code = 4'h3;
        `SZ_N96:  nat_code = 4'h4;
        `SZ_N132: nat_code = 4'h5;
        `SZ_N164: nat_code = 4'h6;
        `SZ_N244: nat_code = 4'h7;
        `SZ_N320: nat_code = 4'h8;
        `SZ_N480: nat_code = 4'h9;
        `SZ_N640: nat_code = 4'ha;
        `SZ_N960: nat_code = 4'hb;
        `SZ_N128: nat_code = 4'hc;
        default:  nat_code = `CODE_NONE;
      endcase
    end
  endfunction

  // interop rate index from payload size, none if not interop
  function [3:0] io_code;
    input [CNT_W-1:0] s;
    begin
      case (s)
        `SZ_I660:  io_code = 4'h0;
        `SZ_I885:  io_code = 4'h1;
        `SZ_I1265: io_code = 4'h2;
        `SZ_I1425: io_code = 4'h3;
        `SZ_I1585: io_code = 4'h4;
        `SZ_I1825: io_code = 4'h5;
        `SZ_I1985: io_code = 4'h6;
        `SZ_I2305: io_code = 4'h7;
        `SZ_I2385: io_code = 4'h8;
        default:   io_code = `CODE_NONE;
      endcase
    end
  endfunction

  // compact request code to interop rate index
  function [3:0] cmr_rate;
    input [2:0] c;
    begin
      case (c)
        3'h0:    cmr_rate = 4'h0;
        3'h1:    cmr_rate = 4'h1;
        3'h2:    cmr_rate = 4'h2;
        3'h3:    cmr_rate = 4'h4;
        3'h4:    cmr_rate = 4'h5;
        3'h5:    cmr_rate = 4'h7;
        3'h6:    cmr_rate = 4'h8;
        default: cmr_rate = `CODE_NONE;
      endcase
    end
  endfunction

  // interop rate index to compact code, none if not expressible
  function [2:0] rate_cmr;
    input [3:0] r;
    begin
      case (r)
        4'h0:    rate_cmr = 3'h0;
        4'h1:    rate_cmr = 3'h1;
        4'h2:    rate_cmr = 3'h2;
        4'h4:    rate_cmr = 3'h3;
        4'h5:    rate_cmr = 3'h4;
        4'h7:    rate_cmr = 3'h5;
        4'h8:    rate_cmr = 3'h6;
        default: rate_cmr = `CMR_NONE;
      endcase
    end
  endfunction

  // highest allowed rate not above the limit
  function [3:0] best_rate;
    input [3:0] lim;
    input [8:0] ms;
    integer i;
    begin
      best_rate = `CODE_NONE;
      for (i = 0; i < 9; i = i + 1)
        if (i <= lim && ms[i])
          best_rate = i[3:0];
    end
  endfunction

  // highest allowed compact code not above the wanted rate
  function [2:0] own_code;
    input [3:0] want;
    input [8:0] ms;
    integer i;
    begin
      own_code = `CMR_NONE;
      for (i = 0; i < 9; i = i + 1)
        if (i <= want && ms[i] && rate_cmr(i[3:0]) != `CMR_NONE)
          own_code = rate_cmr(i[3:0]);
    end
  endfunction

  // merge write data into old value by byte lane
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer i;
    begin
      lane_merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (sel[i])
          lane_merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // ------------
  // register file
  // ------------
  reg  [3:0]  ctrl;
  reg  [8:0]  modeset;
  reg  [3:0]  own_req;
  reg  [4:0]  status;
  reg  [3:0]  peer_req;
  reg         peer_valid;
  reg  [3:0]  eff_rate;
  reg  [31:0] ts;
  reg         ev_pad;
  reg         ev_size;
  reg         ev_div;
  reg         ev_ign;
  reg         ev_req;
  reg         ev_drop;
  reg  [3:0]  ev_rate;
  reg  [31:0] rd_val;
  wire        bus_req = cyc_i & stb_i;
  wire        wr      = bus_req & ack_o & we_i;
  wire [7:0]  a       = {adr_i[7:2], 2'b00};
  wire [31:0] wdat    = lane_merge(rd_val, dat_i, sel_i);
  wire [31:0] wclr    = lane_merge(32'h0000_0000, dat_i, sel_i);
  wire [4:0]  ev_vec  = {ev_ign, ev_drop, ev_div, ev_size, ev_pad};

  assign tx_interop = ctrl[`CTRL_INTEROP];
  assign tx_rate    = eff_rate;

  // read mux, unmapped offsets read zero
  always @*
  begin
    case (a)
      `CTRL_OFS:    rd_val = {28'h000_0000, ctrl};
      `MODESET_OFS: rd_val = {23'h00_0000, modeset};
      `OWNREQ_OFS:  rd_val = {28'h000_0000, own_req};
      `PEERREQ_OFS: rd_val = {23'h00_0000, eff_rate, peer_valid, peer_req};
      `STATUS_OFS:  rd_val = {19'h0_0000, dec_interop, dec_rate, 3'h0, status};
      `TSTAMP_OFS:  rd_val = ts;
      default:      rd_val = 32'h0000_0000;
    endcase
  end

  // ack one cycle after request, writes on the acked edge
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_o      <= 1'b0;
      dat_o      <= 32'h0000_0000;
      ctrl       <= `CTRL_RST;
      modeset    <= `MODESET_RST;
      own_req    <= `OWNREQ_RST;
      status     <= 5'h00;
      peer_req   <= `CODE_NONE;
      peer_valid <= 1'b0;
      eff_rate   <= 4'h8;
    end
    else if (ce)
    begin
      ack_o <= bus_req & ~ack_o;
      if (bus_req & ~ack_o)
        dat_o <= rd_val;
      if (wr && a == `CTRL_OFS)
        ctrl <= wdat[3:0];
      if (wr && a == `MODESET_OFS)
        modeset <= wdat[8:0];
      if (wr && a == `OWNREQ_OFS)
        own_req <= wdat[3:0];
      // new events win over a clear in the same cycle
      status <= (status & ~((wr && a == `STATUS_OFS) ? wclr[4:0] : 5'h00)) | ev_vec;
      // accepted request holds until the next one
      if (ev_req)
      begin
        peer_req   <= ev_rate;
        peer_valid <= 1'b1;
        eff_rate   <= best_rate(ev_rate, modeset);
        ctrl[`CTRL_INTEROP] <= 1'b1;
      end
    end
  end

  // ------------
  // transmit framing
  // ------------
  reg  [2:0] tx_st;
  reg  [7:0] hdr_sr;
  reg  [3:0] hdr_n;
  reg  [2:0] tx_cnt;
  reg        fr_io;
  reg        d0;
  wire       can    = ~tx_valid | tx_ready;
  wire       ts_ld  = wr && a == `TSTAMP_OFS;
  wire       hf     = ctrl[`CTRL_HF_ONLY] | (ctrl[`CTRL_INTEROP] & enc_sid);
  wire [2:0] own_c  = (ctrl[`CTRL_REQ_EN] & ~ctrl[`CTRL_REQ_NATIVE]) ?
                      own_code(own_req, modeset) : `CMR_NONE;
  wire [2:0] req_t  = ctrl[`CTRL_REQ_NATIVE] ? `REQ_T_NATIVE : `REQ_T_INTEROP;

  assign enc_ready = (tx_st == T_HOLD) | (tx_st == T_DROP) | (tx_st == T_BODY & can);

  // frame sequencer, one payload bit per accepted cycle
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_st          <= T_IDLE;
      tx_bit         <= 1'b0;
      tx_valid       <= 1'b0;
      tx_last        <= 1'b0;
      tx_marker      <= 1'b0;
      tx_timestamp   <= 32'h0000_0000;
      tx_header_full <= 1'b0;
      ts             <= 32'h0000_0000;
      hdr_sr         <= 8'h00;
      hdr_n          <= 4'h0;
      tx_cnt         <= 3'h0;
      fr_io          <= 1'b0;
      d0             <= 1'b0;
      ev_drop        <= 1'b0;
    end
    else if (ce)
    begin
      ev_drop <= 1'b0;
      if (tx_valid & tx_ready)
      begin
        tx_valid <= 1'b0;
        tx_last  <= 1'b0;
      end
      if (ts_ld)
        ts <= wdat;
      case (tx_st)
        T_IDLE:
          if (enc_valid & ~tx_valid)
          begin
            if (!ts_ld)
              ts <= ts + TS_STEP;
            tx_timestamp <= ts;
            tx_marker    <= enc_talk_start;
            tx_cnt       <= 3'h0;
            if (enc_damaged)
              tx_st <= T_DROP;
            else if (hf)
            begin
              hdr_sr         <= {1'b1, req_t, own_req};
              hdr_n          <= 4'h8;
              fr_io          <= 1'b0;
              tx_header_full <= 1'b1;
              tx_st          <= T_HDR;
            end
            else if (ctrl[`CTRL_INTEROP])
            begin
              hdr_sr         <= {own_c, 5'h00};
              hdr_n          <= {1'b0, `CMR_BITS};
              fr_io          <= 1'b1;
              tx_header_full <= 1'b0;
              tx_st          <= T_HDR;
            end
            else
            begin
              fr_io          <= 1'b0;
              tx_header_full <= 1'b0;
              tx_st          <= T_BODY;
            end
          end
        T_HDR:
          if (can)
          begin
            tx_bit   <= hdr_sr[7];
            tx_valid <= 1'b1;
            tx_cnt   <= tx_cnt + 3'h1;
            hdr_sr   <= {hdr_sr[6:0], 1'b0};
            hdr_n    <= hdr_n - 4'h1;
            if (hdr_n == 4'h1)
              tx_st <= fr_io ? T_HOLD : T_BODY;
          end
        T_HOLD:
          if (enc_valid)
          begin
            d0    <= enc_bit;
            tx_st <= T_BODY;
          end
        T_BODY:
          if (can & enc_valid)
          begin
            tx_bit   <= enc_bit;
            tx_valid <= 1'b1;
            tx_cnt   <= tx_cnt + 3'h1;
            if (enc_last)
            begin
              if (fr_io)
                tx_st <= T_D0;
              else if (tx_cnt == 3'h7)
              begin
                tx_last <= 1'b1;
                tx_st   <= T_IDLE;
              end
              else
                tx_st <= T_PAD;
            end
          end
        T_D0, T_PAD:
          if (can)
          begin
            tx_bit   <= (tx_st == T_D0) ? d0 : 1'b0;
            tx_valid <= 1'b1;
            tx_cnt   <= tx_cnt + 3'h1;
            if (tx_cnt == 3'h7)
            begin
              tx_last <= 1'b1;
              tx_st   <= T_IDLE;
            end
            else
              tx_st <= T_PAD;
          end
        T_DROP:
          if (enc_valid & enc_last)
          begin
            ev_drop <= 1'b1;
            tx_st   <= T_IDLE;
          end
        default:
          tx_st <= T_IDLE;
      endcase
    end
  end

  // ------------
  // receive parsing
  // ------------
  reg              mem [0:MAX_BITS-1];
  reg  [1:0]       rx_st;
  reg  [CNT_W-1:0] rx_cnt;
  reg  [CNT_W-1:0] out_len;
  reg  [CNT_W-1:0] out_cnt;
  reg              rx_ovf;
  reg  [2:0]       rx_cmr;
  reg  [3:0]       rx_tail;
  wire             take  = rx_valid & rx_ready;
  wire             full  = rx_cnt == MAXC;
  wire [3:0]       nc    = nat_code(rx_cnt);
  wire [3:0]       ic    = io_code(rx_cnt);
  wire [2:0]       pad   = (ic == 4'h0) ? `PAD_66 : (ic == 4'h1) ? `PAD_885 : 3'h0;
  wire [3:0]       padm  = (4'h1 << pad) - 4'h1;
  wire [3:0]       cr    = cmr_rate(rx_cmr);
  wire [CNT_W-1:0] rd_a  = ~dec_interop ? out_cnt :
                           (out_cnt == {CNT_W{1'b0}}) ? out_len + CMR_M1 : out_cnt + CMR_M1;

  assign rx_ready = rx_st == RX_FILL;

  // payload bit store
  always @(posedge ref_clk)
  begin
    if (ce && take && !full)
      mem[rx_cnt] <= rx_bit;
  end

  // fill, classify by size, then replay to the decoder
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_st       <= RX_FILL;
      rx_cnt      <= {CNT_W{1'b0}};
      out_len     <= {CNT_W{1'b0}};
      out_cnt     <= {CNT_W{1'b0}};
      rx_ovf      <= 1'b0;
      rx_cmr      <= 3'h0;
      rx_tail     <= 4'h0;
      dec_bit     <= 1'b0;
      dec_valid   <= 1'b0;
      dec_last    <= 1'b0;
      dec_interop <= 1'b0;
      dec_rate    <= `CODE_NONE;
      hf_divert   <= 1'b0;
      hf_size     <= {CNT_W{1'b0}};
      ev_pad      <= 1'b0;
      ev_size     <= 1'b0;
      ev_div      <= 1'b0;
      ev_ign      <= 1'b0;
      ev_req      <= 1'b0;
      ev_rate     <= 4'h0;
    end
    else if (ce)
    begin
      hf_divert <= 1'b0;
      ev_pad    <= 1'b0;
      ev_size   <= 1'b0;
      ev_div    <= 1'b0;
      ev_ign    <= 1'b0;
      ev_req    <= 1'b0;
      case (rx_st)
        RX_FILL:
          if (take)
          begin
            if (full)
              rx_ovf <= 1'b1;
            else
              rx_cnt <= rx_cnt + ONE;
            if (rx_cnt < CMR_N)
              rx_cmr <= {rx_cmr[1:0], rx_bit};
            rx_tail <= {rx_tail[2:0], rx_bit};
            if (rx_last)
              rx_st <= RX_CLASS;
          end
        RX_CLASS:
        begin
          out_cnt <= {CNT_W{1'b0}};
          out_len <= {CNT_W{1'b0}};
          hf_size <= rx_cnt;
          rx_st   <= RX_OUT;
          if (rx_ovf | (nc == `CODE_NONE & ic == `CODE_NONE) |
              (rx_cnt == `SZ_N28 & rx_cmr[2]))
          begin
            hf_divert <= 1'b1;
            ev_div    <= 1'b1;
            ev_size   <= rx_ovf;
          end
          else if (nc != `CODE_NONE)
          begin
            out_len     <= rx_cnt;
            dec_interop <= 1'b0;
            dec_rate    <= nc;
          end
          else if (|(rx_tail & padm))
            ev_pad <= 1'b1;
          else
          begin
            out_len     <= rx_cnt - CMR_N - {{(CNT_W-3){1'b0}}, pad};
            dec_interop <= 1'b1;
            dec_rate    <= ic;
            if (rx_cmr != `CMR_NONE)
            begin
              if (modeset[cr])
              begin
                ev_req  <= 1'b1;
                ev_rate <= cr;
              end
              else
                ev_ign <= 1'b1;
            end
          end
        end
        RX_OUT:
          if (~dec_valid | dec_ready)
          begin
            if (out_cnt != out_len)
            begin
              dec_bit   <= mem[rd_a];
              dec_valid <= 1'b1;
              dec_last  <= out_cnt == out_len - ONE;
              out_cnt   <= out_cnt + ONE;
            end
            else
            begin
              dec_valid <= 1'b0;
              dec_last  <= 1'b0;
              rx_cnt    <= {CNT_W{1'b0}};
              rx_ovf    <= 1'b0;
              rx_st     <= RX_FILL;
            end
          end
        default:
          rx_st <= RX_FILL;
      endcase
    end
  end

endmodule

// ===== shared/voice_framer_regs.vh
// register map, field positions, reset values and payload sizes
// of the compact payload framer; definitions only, no logic
`ifndef VOICE_FRAMER_REGS_VH
`define VOICE_FRAMER_REGS_VH
// ------------
// register byte offsets
// ------------
`define CTRL_OFS      8'h00
`define MODESET_OFS   8'h04
`define OWNREQ_OFS    8'h08
`define PEERREQ_OFS   8'h0c
`define STATUS_OFS    8'h10
`define TSTAMP_OFS    8'h14
// control bits and reset values
`define CTRL_INTEROP    0
`define CTRL_HF_ONLY    1
`define CTRL_REQ_NATIVE 2
`define CTRL_REQ_EN     3
`define CTRL_RST      4'h0
`define MODESET_RST   9'h1ff
`define OWNREQ_RST    4'h8
// status bits, write one to clear
`define ST_PAD_ERR    0
`define ST_SIZE_ERR   1
`define ST_DIVERT     2
`define ST_DROPPED    3
`define ST_IGNORED    4
// timestamp clock and frame-block length
`define TS_CLOCK_KHZ  32'h0000_0010
`define FRAME_MS      32'h0000_0014
// compact field and request byte
`define CMR_BITS      3'h3
`define CMR_NONE      3'h7
`define REQ_T_INTEROP 3'h1
`define REQ_T_NATIVE  3'h2
`define CODE_NONE     4'hf
`define PAD_66        3'h1
`define PAD_885       3'h4
// native compact sizes in bits
`define SZ_NSID       12'h030
`define SZ_N28        12'h038
`define SZ_N72        12'h090
`define SZ_N80        12'h0a0
`define SZ_N96        12'h0c0
`define SZ_N132       12'h108
`define SZ_N164       12'h148
`define SZ_N244       12'h1e8
`define SZ_N320       12'h280
`define SZ_N480       12'h3c0
`define SZ_N640       12'h500
`define SZ_N960       12'h780
`define SZ_N128       12'ha00
// interop compact sizes in bits
`define SZ_I660       12'h088
`define SZ_I885       12'h0b8
`define SZ_I1265      12'h100
`define SZ_I1425      12'h120
`define SZ_I1585      12'h140
`define SZ_I1825      12'h170
`define SZ_I1985      12'h190
`define SZ_I2305      12'h1d0
`define SZ_I2385      12'h1e0
`endif

// ===== verification/voice_rtp_compact_payload_framer_assertions.sv
// port checker for the compact payload framer
// assumes ce stays high while frames are in flight
`timescale 1ns/1ps
module framer_checker (
  // watched ports
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        ce,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic        tx_bit,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        tx_last,
  input wire logic [31:0] tx_timestamp,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic        rx_last,
  input wire logic        dec_valid,
  input wire logic        dec_last,
  input wire logic        hf_divert
);
  // ------------
  // properties
  // ------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence bus_req; cyc_i && stb_i && !ack_o && ce; endsequence
  sequence rx_end; rx_valid && rx_ready && rx_last && ce; endsequence
  a_ack_next: assert property (bus_req |=> ack_o)
    else $error("bus request not answered");
  a_ack_single: assert property (ack_o && ce |=> !ack_o)
    else $error("ack longer than one cycle");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_bit))
    else $error("payload bit dropped while stalled");
  a_ts_step: assert property ($changed(tx_timestamp) |->
    tx_timestamp == $past(tx_timestamp) + 32'h0000_0140)
    else $error("timestamp step not 320");
  a_rx_refuse: assert property (rx_end |=> !rx_ready [*2])
    else $error("bits accepted during classify");
  a_rx_classify: assert property (rx_end |-> ##[2:3] (dec_valid || hf_divert))
    else $error("received payload not classified");
  a_divert_pulse: assert property (hf_divert |=> !hf_divert)
    else $error("divert longer than one cycle");
  a_last_qual: assert property ((tx_last |-> tx_valid) and (dec_last |-> dec_valid))
    else $error("last flag without valid");
endmodule
bind voice_rtp_compact_payload_framer framer_checker i_chk (.*);

// ===== verification/peer_endpoint_model.sv
// peer media endpoint: sinks and sources payload bits
// assumes the framer clock; the bench fills pl and calls send
`timescale 1ns/1ps
module peer_endpoint_model (
  // clock
  input  wire logic ref_clk,
  // payload from the framer
  input  wire logic tx_bit,
  input  wire logic tx_valid,
  output logic      tx_ready,
  // payload to the framer
  output logic      rx_bit,
  output logic      rx_valid,
  output logic      rx_last,
  input  wire logic rx_ready
);
  // ------------
  // sink and source state
  // ------------
  logic cap [4096];
  logic pl  [2560];
  int   cnt = 0;
  logic slow = 1'b0;
  initial {tx_ready, rx_bit, rx_valid, rx_last} = 4'h8;
  // capture accepted bits, stall every other cycle when slow
  always @(posedge ref_clk)
  begin
    if (tx_valid && tx_ready)
    begin
      cap[cnt] <= tx_bit;
      cnt      <= cnt + 1;
    end
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // send n bits in order, holding each until taken
  task send(input int n);
    int i;
    int k;
    i = 0;
    for (k = 0; k < 5000 && i < n; k++)
    begin
      rx_valid <= 1'b1;
      rx_bit   <= pl[i];
      rx_last  <= (i == n - 1);
      @(posedge ref_clk);
      if (rx_ready === 1'b1)
        i++;
    end
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    rx_bit   <= ~rx_bit; // released line does not keep its level
  endtask
endmodule

// ===== verification/voice_rtp_compact_payload_framer_tb_top.sv
// bench for the compact payload framer: registers, native and
// interop transmit, interop and unknown-size receive
// assumes the peer model and the checker are compiled first
`timescale 1ns/1ps
`include "voice_framer_regs.vh"
module voice_rtp_compact_payload_framer_tb_top;
  // ------------
  // signals
  // ------------
  logic        ref_clk = 0, reset_n = 0, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0]  adr_i = 0;
  logic [31:0] dat_i = 0, dat_o, tx_timestamp, q;
  logic [3:0]  sel_i = 0, tx_rate, dec_rate;
  logic        enc_bit = 0, enc_valid = 0, enc_last = 0, enc_talk_start = 0;
  logic        ce = 1, enc_sid = 0, enc_damaged = 0, dec_ready = 1;
  logic        ack_o, enc_ready, tx_interop, tx_bit, tx_valid, tx_last, tx_ready;
  logic        tx_marker, tx_header_full, rx_bit, rx_valid, rx_last, rx_ready;
  logic        dec_bit, dec_valid, dec_last, dec_interop, hf_divert;
  logic [11:0] hf_size;
  logic        dcap [4096];
  int          dcnt = 0, ndiv = 0, failures = 0, num_checks = 0;
  voice_rtp_compact_payload_framer i_voice_rtp_compact_payload_framer (.*);
  peer_endpoint_model i_peer (.*);
  // clock and decoder capture
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    if (dec_valid)
    begin
      dcap[dcnt] <= dec_bit;
      dcnt       <= dcnt + 1;
    end
    if (hf_divert)
      ndiv <= ndiv + 1;
  end
  // ------------
  // helpers
  // ------------
  function logic pb(input int i);
    return i[0] ^ i[2] ^ (i > 5);
  endfunction
  // expected payload bit k: native as produced, interop code, d1.., d0, pad
  function logic ex(input int k, input int n, input logic [2:0] c);
    if (n == 48) return pb(k);
    if (k < 3) return c[2 - k];
    if (k < 134) return pb(k - 2);
    return (k == 134) ? pb(0) : 1'b0;
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task bound(input int k, input int lim);
    if (k >= lim)
    begin
      failures++;
      print_verdict();
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hf};
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (ack_o !== 1'b1 && k < 50);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    @(posedge ref_clk);
    bound(k, 50);
  endtask
  task enc_frame(input int n, input logic talk);
    int i;
    int k;
    i = 0;
    enc_valid      <= 1'b1;
    enc_talk_start <= talk;
    for (k = 0; k < 9000 && i < n; k++)
    begin
      enc_bit  <= pb(i);
      enc_last <= (i == n - 1);
      @(posedge ref_clk);
      if (enc_ready === 1'b1)
        i++;
    end
    {enc_valid, enc_last} <= 2'b00;
    bound(k, 9000);
  endtask
  task chk_tx(input int b, input int n, input logic [2:0] c);
    int k;
    for (k = 0; k < 9000 && i_peer.cnt < b + n; k++)
      @(posedge ref_clk);
    bound(k, 9000);
    for (k = 0; k < n; k++)
      chk("tx bit", ex(k, n, c), i_peer.cap[b + k]);
  endtask
  // ------------
  // scenarios
  // ------------
  task check_regs;
    wb(1'b0, `MODESET_OFS, 0);
    chk("modeset", 32'h0000_01ff, q);
    wb(1'b0, `OWNREQ_OFS, 0);
    chk("ownreq", 32'h0000_0008, q);
    wb(1'b1, `PEERREQ_OFS, 32'hffff_ffff);
    wb(1'b0, `PEERREQ_OFS, 0);
    chk("peer valid", 0, q & 32'h0000_0010);
    wb(1'b0, 8'h18, 0);
    chk("unmapped", 0, q);
  endtask
  task check_native_tx;
    int b;
    b = i_peer.cnt;
    i_peer.slow = 1'b1;
    enc_frame(48, 1'b1);
    chk_tx(b, 48, 3'h0);
    chk("marker", 1, tx_marker);
    chk("timestamp", 0, tx_timestamp);
    chk("header full", 0, tx_header_full);
  endtask
  task check_rx(input logic [2:0] c, input logic [3:0] rate, input logic mode);
    int k;
    int d;
    d = dcnt;
    for (k = 0; k < 136; k++)
      i_peer.pl[k] = ex(k, 136, c);
    i_peer.send(136);
    for (k = 0; k < 600 && dcnt < d + 132; k++)
      @(posedge ref_clk);
    bound(k, 600);
    for (k = 0; k < 132; k++)
      chk("dec bit", pb(k), dcap[d + k]);
    chk("dec mode", 32'h0000_0010, {dec_interop, dec_rate});
    chk("tx mode", {mode, rate}, {tx_interop, tx_rate});
  endtask
  task check_interop_tx;
    int b;
    b = i_peer.cnt;
    i_peer.slow = 1'b0;
    wb(1'b1, `CTRL_OFS, 32'h0000_0009);
    wb(1'b1, `OWNREQ_OFS, 32'h0000_0006);
    enc_frame(132, 1'b0);
    chk_tx(b, 136, 3'h4);
    chk("marker", 0, tx_marker);
    chk("timestamp", 32'h0000_0140, tx_timestamp);
  endtask
  task check_divert;
    int k;
    for (k = 0; k < 100; k++)
      i_peer.pl[k] = pb(k);
    i_peer.send(100);
    repeat (4) @(posedge ref_clk);
    chk("divert", 1, ndiv);
    chk("hf size", 100, hf_size);
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    check_regs();
    check_native_tx();
    check_rx(3'h7, 4'h8, 1'b0);
    check_rx(3'h0, 4'h0, 1'b1);
    check_interop_tx();
    check_divert();
    print_verdict();
  end
endmodule
